/* File: dmad_cfg.svh */
// Purpose: Constants for the data memory address decoder
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef DMAD_CFG_SVH
`define DMAD_CFG_SVH
// ----------------------------------------
// Program store
// ----------------------------------------
`define DMAD_PC_STEP_W   8
`define DMAD_PC_PAGE_W   4
`define DMAD_ROM_AW      12
`define DMAD_ROM_DW      12
`define DMAD_ROM_WORDS   4096
`define DMAD_RESET_PAGE  4'h1
`define DMAD_RESET_STEP  8'h00
`define DMAD_VEC_LO      8'h02
`define DMAD_VEC_HI      8'h0F
// ----------------------------------------
// Data map
// ----------------------------------------
`define DMAD_DW          4
`define DMAD_PAGE_W      4
`define DMAD_LOW_W       8
`define DMAD_RAM_WORDS   512
`define DMAD_RAM_PER_PG  128
`define DMAD_RAM_PAGES   4
`define DMAD_DISP_WORDS  32
`define DMAD_IO_WORDS    56
`define DMAD_IO_SLOTS    64
`define DMAD_DISP_LO     8'h80
`define DMAD_DISP_HI     8'h9F
`define DMAD_IO_LO       8'hC0
`define DMAD_IO_HI       8'hFF
`define DMAD_RAM_HI      8'h7F
`define DMAD_REGAREA_HI  8'h0F
`define DMAD_STACK_PUSH  3
`define DMAD_UNMAPPED_RD 4'h0
`endif

/* File: dmad_pkg.sv */
// Purpose: Types for the data memory address decoder
// Assumes: dmad_cfg.svh defines the widths
// Notes:   Types only
`include "dmad_cfg.svh"
package dmad_pkg;
  // ----------------------------------------
  // Region selects
  // ----------------------------------------
  typedef enum logic [2:0] {
    DMAD_REG_NONE = 3'h0,
    DMAD_REG_RAM  = 3'h1,
    DMAD_REG_DISP = 3'h2,
    DMAD_REG_IO   = 3'h3
  } dmad_region_type;

  // Data access from the core
  typedef struct packed {
    logic                        rd;
    logic                        wr;
    logic [`DMAD_PAGE_W-1:0]     page;
    logic [`DMAD_LOW_W-1:0]      low;
    logic [`DMAD_DW-1:0]         wdata;
  } dmad_dreq_type;

  // Strobe toward display memory or I/O register file
  typedef struct packed {
    logic                        rd;
    logic                        wr;
    logic [5:0]                  addr;
    logic [`DMAD_DW-1:0]         wdata;
  } dmad_side_type;
endpackage : dmad_pkg

/* File: dmad_ram.sv */
// Purpose: Data RAM, flip-flop array addressed by index
// Assumes: Single port, synchronous write, registered read data
// Notes:   Contents not reset, like the real array
`timescale 1ns/1ps
`include "dmad_cfg.svh"
module dmad_ram #(
  parameter int WORDS = `DMAD_RAM_WORDS,
  parameter int DW    = `DMAD_DW
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(WORDS)-1:0] addr,
  input  wire logic [DW-1:0]            wdata,
  output logic      [DW-1:0]            rdata
);
  logic [DW-1:0] mem [WORDS];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Array left unreset: no reset value is promised
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : dmad_ram

/* File: dmad_decoder.sv */
// What this block does
// - The program store is 4096 words of 12 bits, so no bank bits are formed.
// - The bank register and next bank pointer inputs never affect the fetch address.
// - The fetch address is a 4-bit page of 16 and an 8-bit step of 256.
// - After reset the first fetch is page 1 step 00H.
// - Interrupt entry fetches from page 1 at a vector step between 02H and 0FH.
// - Only the two low bits of the index page field take part in data decode.
// - Data RAM holds 512 read/write words of 4 bits over the pages.
// - Each page decodes 128 RAM words at low addresses 00H to 7FH.
// - Each call or interrupt pushes three 4-bit words into RAM.
// - Addresses 000H to 00FH form the register area and are flagged as such.
// - Peripheral registers are reached only by ordinary data reads and writes.
// - The decoded space is 32 display words, 64 I/O words and 128 RAM words per page; A0H-BFH is unmapped.
// - Display at 80H-9FH and I/O at C0H-FFH decode the same on every page.
// - Display memory takes writes only and never returns read data.
//
// Purpose: Program fetch address and data memory decoder for a 4-bit core
// Assumes: Core drives requests synchronous to clk; one access per cycle
// Notes:   Read data returns one cycle after the read strobe
`timescale 1ns/1ps
`include "dmad_cfg.svh"
module dmad_decoder #(
  parameter int RAM_WORDS = `DMAD_RAM_WORDS
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // Program fetch side
  input  wire logic                          fetchLoad,
  input  wire logic [`DMAD_PC_PAGE_W-1:0]    loadPage,
  input  wire logic [`DMAD_PC_STEP_W-1:0]    loadStep,
  input  wire logic                          fetchAdvance,
  input  wire logic                          intEntry,
  input  wire logic [`DMAD_PC_STEP_W-1:0]    intVector,
  input  wire logic [3:0]                    programBankReg,
  input  wire logic [3:0]                    nextBankPointer,
  output logic      [`DMAD_ROM_AW-1:0]       fetchAddr,
  // Data side
  input  wire dmad_pkg::dmad_dreq_type       dataReq,
  input  wire logic                          stackPush,
  output logic      [`DMAD_DW-1:0]           dataRdata,
  output logic                               dataRvalid,
  output logic                               regAreaHit,
  output logic                               unmappedHit,
  output logic      [1:0]                    stackWords,
  // Display and I/O strobes
  output dmad_pkg::dmad_side_type            dispPort,
  output dmad_pkg::dmad_side_type            ioPort,
  input  wire logic [`DMAD_DW-1:0]           ioRdata
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [`DMAD_PC_PAGE_W-1:0] page;
    logic [`DMAD_PC_STEP_W-1:0] step;
    dmad_pkg::dmad_region_type  rdRegion;
    logic                       rvalid;
    logic                       regHit;
    logic                       unmapHit;
    logic [1:0]                 pushCnt;
    dmad_pkg::dmad_side_type    disp;
    dmad_pkg::dmad_side_type    io;
  } dmad_state_type;

  dmad_state_type st_q;
  dmad_state_type st_d;
  logic [$clog2(RAM_WORDS)-1:0] ramAddr;
  logic                         ramWe;
  logic [`DMAD_DW-1:0]          ramRdata;
  dmad_pkg::dmad_region_type    region;

  // ----------------------------------------
  // Decode function
  // ----------------------------------------
  // Page ignored for display and I/O: mirrored on all pages
  function automatic dmad_pkg::dmad_region_type decodeLow(input logic [`DMAD_LOW_W-1:0] low);
    if (low <= `DMAD_RAM_HI) begin
      decodeLow = dmad_pkg::DMAD_REG_RAM;
    end else if (low >= `DMAD_DISP_LO && low <= `DMAD_DISP_HI) begin
      decodeLow = dmad_pkg::DMAD_REG_DISP;
    end else if (low >= `DMAD_IO_LO) begin
      decodeLow = dmad_pkg::DMAD_REG_IO;
    end else begin
      decodeLow = dmad_pkg::DMAD_REG_NONE;
    end
  endfunction : decodeLow

  assign region = decodeLow(dataReq.low);
  // Only page bits 1:0 form the RAM index
  assign ramAddr = {dataReq.page[1:0], dataReq.low[6:0]};
  assign ramWe   = dataReq.wr && (region == dmad_pkg::DMAD_REG_RAM);

  // ----------------------------------------
  // RAM instance
  // ----------------------------------------
  dmad_ram #(
    .WORDS (RAM_WORDS),
    .DW    (`DMAD_DW)
  ) u_ram (
    .clk   (clk),
    .we    (ramWe),
    .addr  (ramAddr),
    .wdata (dataReq.wdata),
    .rdata (ramRdata)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Bank inputs deliberately unread: 4096 words need no bank
  always_comb begin
    st_d          = st_q;
    st_d.rvalid   = dataReq.rd;
    st_d.rdRegion = region;
    st_d.regHit   = (dataReq.rd || dataReq.wr) && (dataReq.page[1:0] == 2'h0)
                    && (dataReq.low <= `DMAD_REGAREA_HI);
    st_d.unmapHit = (dataReq.rd || dataReq.wr) && (region == dmad_pkg::DMAD_REG_NONE);
    // Fetch address sequencing, interrupt wins over jump
    if (intEntry) begin
      st_d.page = `DMAD_RESET_PAGE;
      st_d.step = (intVector < `DMAD_VEC_LO) ? `DMAD_VEC_LO
                : (intVector > `DMAD_VEC_HI) ? `DMAD_VEC_HI : intVector;
    end else if (fetchLoad) begin
      st_d.page = loadPage;
      st_d.step = loadStep;
    end else if (fetchAdvance) begin
      st_d.step = st_q.step + 8'h01;
    end
    // Count pushes into stack RAM, three per entry
    if (stackPush && ramWe) begin
      st_d.pushCnt = (st_q.pushCnt == 2'(`DMAD_STACK_PUSH - 1)) ? 2'h0 : st_q.pushCnt + 2'h1;
    end
    // Side strobes: ordinary memory accesses only
    st_d.disp.rd    = 1'b0;
    st_d.disp.wr    = dataReq.wr && (region == dmad_pkg::DMAD_REG_DISP);
    st_d.disp.addr  = {1'b0, dataReq.low[4:0]};
    st_d.disp.wdata = dataReq.wdata;
    st_d.io.rd      = dataReq.rd && (region == dmad_pkg::DMAD_REG_IO);
    st_d.io.wr      = dataReq.wr && (region == dmad_pkg::DMAD_REG_IO);
    st_d.io.addr    = dataReq.low[5:0];
    st_d.io.wdata   = dataReq.wdata;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q          <= '0;
      st_q.page     <= `DMAD_RESET_PAGE;
      st_q.step     <= `DMAD_RESET_STEP;
      st_q.rdRegion <= dmad_pkg::DMAD_REG_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fetchAddr   = {st_q.page, st_q.step};
  assign dataRvalid  = st_q.rvalid;
  assign regAreaHit  = st_q.regHit;
  assign unmappedHit = st_q.unmapHit;
  assign stackWords  = st_q.pushCnt;
  assign dispPort    = st_q.disp;
  assign ioPort      = st_q.io;

  // Display and unused reads give a fixed value
  always_comb begin
    case (st_q.rdRegion)
      dmad_pkg::DMAD_REG_RAM:  dataRdata = ramRdata;
      dmad_pkg::DMAD_REG_IO:   dataRdata = ioRdata;
      default:                 dataRdata = `DMAD_UNMAPPED_RD;
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Fetch sequencing
  reset_start_a: assert property (@(posedge clk) $rose(resetn) |-> fetchAddr == 12'h100)
    else $error("fetch did not start at page 1 step 0");
  vector_range_a: assert property (@(posedge clk) disable iff (!resetn)
    intEntry |=> (fetchAddr[11:8] == 4'h1 && fetchAddr[7:0] >= 8'h02 && fetchAddr[7:0] <= 8'h0F))
    else $error("interrupt vector out of range");
  vector_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
    (intEntry && intVector > 8'h0F) |=> fetchAddr == 12'h10F)
    else $error("high interrupt vector not clamped");
  bank_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
    (fetchLoad && !intEntry) |=> fetchAddr == $past({loadPage, loadStep}))
    else $error("fetch address not taken from load");
  bank_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    ($changed(programBankReg) || $changed(nextBankPointer)) && !fetchLoad && !fetchAdvance && !intEntry |=> $stable(fetchAddr))
    else $error("bank input moved the fetch address");
  step_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    (fetchAdvance && !fetchLoad && !intEntry) |=> fetchAddr[7:0] == $past(fetchAddr[7:0]) + 8'h01
      && fetchAddr[11:8] == $past(fetchAddr[11:8]))
    else $error("step advance wrong");
  // Data decode
  disp_mirror_a: assert property (@(posedge clk) disable iff (!resetn)
    (dataReq.wr && dataReq.low >= 8'h80 && dataReq.low <= 8'h9F) |=> dispPort.wr && !ioPort.wr)
    else $error("display write not decoded");
  disp_noread_a: assert property (@(posedge clk) disable iff (!resetn)
    (dataReq.rd && dataReq.low >= 8'h80 && dataReq.low <= 8'h9F) |=> dataRdata == 4'h0 && !dispPort.rd)
    else $error("display read returned data");
  io_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
    (dataReq.rd && dataReq.low >= 8'hC0) |=> ioPort.rd && ioPort.addr == $past(dataReq.low[5:0]))
    else $error("I/O read not strobed");
  unmapped_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    (dataReq.wr && dataReq.low >= 8'hA0 && dataReq.low <= 8'hBF) |-> !ramWe ##1 (unmappedHit && !dispPort.wr && !ioPort.wr))
    else $error("unmapped write not dropped");
  page_low_a: assert property (@(posedge clk) disable iff (!resetn)
    (dataReq.wr && dataReq.low <= 8'h7F) |-> ramWe && ramAddr[8:7] == dataReq.page[1:0])
    else $error("RAM index formed wrongly");
  reg_area_a: assert property (@(posedge clk) disable iff (!resetn)
    ((dataReq.rd || dataReq.wr) && dataReq.page[1:0] == 2'h0 && dataReq.low < 8'h10) |=> regAreaHit)
    else $error("register area not flagged");
  push_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    (stackPush && dataReq.wr && dataReq.low <= 8'h7F && stackWords == 2'h2) |=> stackWords == 2'h0)
    else $error("stack word count did not wrap after three");
endmodule : dmad_decoder

/* File: dmad_io_model.sv */
// Purpose: Behavioural I/O register file on the far side of the ioPort strobe
// Assumes: Writes land on the rising edge; read data is combinational
// Notes:   Idle output is inverted so a stale value cannot pass for a real read
`timescale 1ns/1ps
module dmad_io_model (
  input  wire logic                 clk,
  input  wire dmad_pkg::dmad_side_type ioPort,
  output logic [3:0]                ioRdata
);
  logic [3:0] mem [64];
  // --------------------------------
  // Storage
  // --------------------------------
  // Peripheral state reached only by plain data writes
  always_ff @(posedge clk) begin
    if (ioPort.wr) begin
      mem[ioPort.addr] <= ioPort.wdata;
    end
  end
  // Not selected: show the inverse, never the last value
  assign ioRdata = ioPort.rd ? mem[ioPort.addr] : ~mem[ioPort.addr];
endmodule : dmad_io_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the data memory address decoder
// Assumes: Inputs change on the rising edge by non-blocking assignment
// Notes:   Registered outputs are checked 1 ns after the answering edge
`timescale 1ns/1ps
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin nFail++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
  logic clk, resetn, fetchLoad, fetchAdvance, intEntry, stackPush;
  logic [3:0] loadPage, programBankReg, nextBankPointer, dataRdata, ioRdata;
  logic [7:0] loadStep, intVector;
  logic [11:0] fetchAddr;
  logic dataRvalid, regAreaHit, unmappedHit;
  logic [1:0] stackWords;
  dmad_pkg::dmad_dreq_type dataReq;
  dmad_pkg::dmad_side_type dispPort, ioPort;
  int nFail = 0;
  int cmpCount = 0;
  // --------------------------------
  // Instances
  // --------------------------------
  dmad_decoder u_dut (.clk(clk), .resetn(resetn), .fetchLoad(fetchLoad), .loadPage(loadPage),
    .loadStep(loadStep), .fetchAdvance(fetchAdvance), .intEntry(intEntry), .intVector(intVector),
    .programBankReg(programBankReg), .nextBankPointer(nextBankPointer), .fetchAddr(fetchAddr),
    .dataReq(dataReq), .stackPush(stackPush), .dataRdata(dataRdata), .dataRvalid(dataRvalid),
    .regAreaHit(regAreaHit), .unmappedHit(unmappedHit), .stackWords(stackWords),
    .dispPort(dispPort), .ioPort(ioPort), .ioRdata(ioRdata));
  dmad_io_model u_io (.clk(clk), .ioPort(ioPort), .ioRdata(ioRdata));
  // --------------------------------
  // Clock, watchdog, verdict
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run is well under 200 cycles; 2000 leaves margin
  initial begin
    #200000;
    nFail++;
    conclude();
  end
  task automatic conclude();
    if (nFail == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // One access, then idle; answer is visible after the second edge
  task automatic acc(input logic r, input logic w, input logic [3:0] pg, input logic [7:0] lo,
                     input logic [3:0] wd, input logic sp);
    @(posedge clk) begin
      dataReq <= {r, w, pg, lo, wd};
      stackPush <= sp;
    end
    @(posedge clk) begin
      dataReq <= '0;
      stackPush <= 1'b0;
    end
    #1;
  endtask : acc
  // Bank inputs are scrambled every call; they must not move the fetch
  task automatic fet(input logic ld, input logic adv, input logic ie, input logic [3:0] pg,
                     input logic [7:0] st, input logic [7:0] vec, input logic [3:0] bank);
    @(posedge clk) begin
      fetchLoad <= ld;
      fetchAdvance <= adv;
      intEntry <= ie;
      loadPage <= pg;
      loadStep <= st;
      intVector <= vec;
      programBankReg <= bank;
      nextBankPointer <= ~bank;
    end
    @(posedge clk) {fetchLoad, fetchAdvance, intEntry} <= 3'h0;
    #1;
  endtask : fet
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_fetch();
    fet(1'b1, 1'b0, 1'b0, 4'hF, 8'hFF, 8'h00, 4'h5);
    `CHK(fetchAddr, 12'hFFF)
    fet(1'b0, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00, 4'hA);
    `CHK(fetchAddr, 12'hF00)
    fet(1'b1, 1'b0, 1'b1, 4'h7, 8'h33, 8'h0F, 4'h3);
    `CHK(fetchAddr, 12'h10F)
    fet(1'b0, 1'b0, 1'b1, 4'h0, 8'h00, 8'h02, 4'hC);
    `CHK(fetchAddr, 12'h102)
    fet(1'b0, 1'b0, 1'b0, 4'h9, 8'h99, 8'h00, 4'hE);
    `CHK(fetchAddr, 12'h102)
    fet(1'b0, 1'b0, 1'b1, 4'h0, 8'h00, 8'h40, 4'h1);
    `CHK(fetchAddr, 12'h10F)
    fet(1'b0, 1'b0, 1'b1, 4'h0, 8'h00, 8'h01, 4'h1);
    `CHK(fetchAddr, 12'h102)
  endtask : t_fetch
  // Same low address on all four pages, read back with page bit 2 set
  task automatic t_ram();
    for (int i = 0; i < 4; i++) acc(1'b0, 1'b1, 4'(i), 8'h7F, 4'(i + 3), 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, 4'(i + 4), 8'h7F, 4'h0, 1'b0);
      `CHK(dataRvalid, 1'b1)
      `CHK(dataRdata, 4'(i + 3))
    end
    acc(1'b0, 1'b1, 4'h0, 8'h0F, 4'h1, 1'b0);
    `CHK(regAreaHit, 1'b1)
    acc(1'b0, 1'b1, 4'h0, 8'h10, 4'h1, 1'b0);
    `CHK(regAreaHit, 1'b0)
  endtask : t_ram
  task automatic t_disp();
    acc(1'b0, 1'b1, 4'h2, 8'h9F, 4'h6, 1'b0);
    `CHK(dispPort.wr, 1'b1)
    `CHK(dispPort.addr, 6'h1F)
    `CHK(dispPort.wdata, 4'h6)
    acc(1'b1, 1'b0, 4'h1, 8'h9F, 4'h0, 1'b0);
    `CHK(dispPort.rd, 1'b0)
    `CHK(dataRdata, 4'h0)
  endtask : t_disp
  // Written on one page, read on another
  task automatic t_io();
    acc(1'b0, 1'b1, 4'h1, 8'hC5, 4'hA, 1'b0);
    `CHK(ioPort.wr, 1'b1)
    acc(1'b0, 1'b1, 4'h0, 8'hFF, 4'h9, 1'b0);
    acc(1'b1, 1'b0, 4'h3, 8'hC5, 4'h0, 1'b0);
    `CHK(ioPort.addr, 6'h05)
    `CHK(dataRdata, 4'hA)
    acc(1'b1, 1'b0, 4'h2, 8'hFF, 4'h0, 1'b0);
    `CHK(dataRdata, 4'h9)
  endtask : t_io
  task automatic t_unmap();
    acc(1'b0, 1'b1, 4'h0, 8'hA0, 4'h5, 1'b0);
    `CHK(unmappedHit, 1'b1)
    `CHK({dispPort.wr, ioPort.wr}, 2'h0)
    acc(1'b1, 1'b0, 4'h0, 8'hBF, 4'h0, 1'b0);
    `CHK(dataRdata, 4'h0)
  endtask : t_unmap
  // Count wraps after three pushed words
  task automatic t_stack();
    for (int k = 1; k <= 3; k++) begin
      acc(1'b0, 1'b1, 4'h0, 8'(8'h40 + k), 4'(k), 1'b1);
      `CHK(stackWords, 2'(k % 3))
    end
  endtask : t_stack
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    resetn = 1'b0;
    {fetchLoad, fetchAdvance, intEntry, stackPush} = 4'h0;
    {loadPage, programBankReg, nextBankPointer, loadStep, intVector} = '0;
    dataReq = '0;
    repeat (3) @(posedge clk);
    `CHK(fetchAddr, 12'h100)
    resetn <= 1'b1;
    #1;
    `CHK(fetchAddr, 12'h100)
    t_fetch();
    t_ram();
    t_disp();
    t_io();
    t_unmap();
    t_stack();
    conclude();
  end
endmodule : tb_top
